// ---- hw/uart_rx_cfg.svh ----
/*
   Constants of the serial receiver: register word indices, field reset values
   and oversample tick positions. Assumes a 16x oversample enable from a divider.
*/
// How it works
// - Serial input is sampled on every oversample tick, sixteen ticks per bit.
// - Tick phase realigns at each start edge and on a data high-to-low change.
// - Start found as a low sample after three highs; counter then loads tick 2.
// - Ticks 3, 5, 7 verify start; one high accepted with noise, more rejected.
// - Failed start verification resets the counter and restarts the search.
// - Data bit is majority of ticks 8, 9, 10; any disagreement flags noise.
// - High samples at ticks 8 to 10 of a start bit flag noise only.
// - Stop bit is majority of ticks 8 to 10; low sets stop error, disagreement noise.
// - Stop error flag rises in the same cycle as the buffer-full flag.
// - A break character, lacking a high stop bit, raises the stop error flag.
// - Valid falling edges inside a character realign the tick counter.
// - Standby bit puts receiver in standby; receive requests are held off there.
// - Address-mark wake: high top bit clears standby and fills the buffer.
// - Idle-line wake: idle clears standby without idle or buffer-full flags.
// - Idle select bit starts counting highs after the start or after the stop bit.
// - In idle-line wake, setting standby while line is already idle wakes the receiver again.
// - Length select chooses eight or nine data bits before the stop bit.
// - Idle flag rises after 10 or 11 consecutive high bits on the line.
// - A complete character received outside standby, or one that address-wakes, moves to the buffer and raises buffer-full.
`ifndef UART_RX_CFG_SVH
`define UART_RX_CFG_SVH

// ------------------------------------------------------------
// Register word indices (byte address = 4 * index)
// ------------------------------------------------------------
`define RX_WORD_CTRL 6'h00
`define RX_WORD_STAT 6'h01
`define RX_WORD_DATA 6'h02
`define RX_WORD_DIV 6'h03

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RX_CTRL_RST 5'h00
`define RX_STAT_RST 5'h00
`define RX_DIV_RST 16'h0035

// ------------------------------------------------------------
// Oversample tick positions within a bit
// ------------------------------------------------------------
`define RT_FIRST 5'h01
`define RT_AFTER_EDGE 5'h02
`define RT_VER_A 5'h03
`define RT_VER_B 5'h05
`define RT_VER_C 5'h07
`define RT_EARLY_EDGE 5'h05
`define RT_WIN_A 5'h08
`define RT_WIN_B 5'h09
`define RT_WIN_C 5'h0a
`define RT_LATE_EDGE 5'h0b
`define RT_LAST 5'h10

// ------------------------------------------------------------
// Character shape
// ------------------------------------------------------------
`define LAST_BIT_8 4'h7
`define LAST_BIT_9 4'h8
`define IDLE_TICKS_8 8'ha0
`define IDLE_TICKS_9 8'hb0

`endif

// ---- hw/uart_rx_pkg.sv ----
/*
   Types and helpers shared by the serial receiver files.
   Assumes uart_rx_cfg.svh supplies the numeric constants.
*/
package uart_rx_pkg;

   typedef enum logic [1:0] {ST_HUNT, ST_START, ST_DATA, ST_STOP} rx_state_e;

   // Bit 0 upward: enable, char9, wake_addr, idle_count_start_select, standby
   typedef struct packed {
      logic standby;
      logic idle_count_start_select;
      logic wake_addr;
      logic char9;
      logic enable;
   } ctrl_s;

   // Bit 0 upward: rbf, idle, nf, fe, active
   typedef struct packed {
      logic active;
      logic fe;
      logic nf;
      logic idle;
      logic rbf;
   } status_s;

   function automatic logic majority3(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   function automatic logic disagree3(input logic [2:0] s);
      return (s != 3'h0) && (s != 3'h7);
   endfunction

endpackage

// ---- hw/rt_tick_gen.sv ----
/*
   Oversample tick divider: one-cycle enable every divisor+1 clocks.
   Assumes software sets the divisor for sixteen ticks per bit time.
*/
`timescale 1ns/1ps
`default_nettype none
module rt_tick_gen (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // Control
   input wire logic i_enable,
   input wire logic [15:0] i_divisor,
   // Tick
   output logic o_tick
);
   logic [15:0] cnt_r;
   wire wrap_w = (cnt_r >= i_divisor);

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cnt_r <= 16'h0000;
         o_tick <= 1'b0;
      end else begin
         cnt_r <= (!i_enable || wrap_w) ? 16'h0000 : cnt_r + 16'h0001;
         o_tick <= i_enable & wrap_w;
      end
   end

   property p_tick_needs_enable;
      @(posedge i_clock) disable iff (i_rst) o_tick |-> $past(i_enable);
   endproperty
   a_tick_needs_enable: assert property (p_tick_needs_enable) else $error("tick without enable");

endmodule
`default_nettype wire

// ---- hw/uart_rx_sampling_wakeup.sv ----
/*
   Receive data recovery with 16x oversampling, start verification, majority
   voting, resync, idle detection and standby wakeup behind a Wishbone slave.
   Assumes a synchronous serial input and a classic Wishbone master.
*/
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_cfg.svh"
module uart_rx_sampling_wakeup
   import uart_rx_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Serial line
   input wire logic i_rxd,
   // Receiver state
   output logic o_rx_request,
   output logic o_standby
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   ctrl_s ctrl_r, ctrl_nxt;
   status_s status_r, status_nxt;
   logic [15:0] div_r;
   logic [8:0] rx_buf_r;
   logic idle_armed_r;
   logic [7:0] idle_cnt_r;
   rx_state_e state_r, state_nxt;
   logic [4:0] tick_cnt_r, tick_nxt;
   logic [2:0] hist_r, hist_nxt;
   logic [2:0] ver_r, ver_nxt;
   logic [2:0] win_r, win_nxt;
   logic [3:0] bit_idx_r, idx_nxt;
   logic [8:0] shift_r, shift_nxt;
   logic last_vote_r, vote_nxt;
   logic chr_noise_r, noise_nxt;
   logic tick_w;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire bus_req_w = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire wr_w = bus_req_w & i_wb_we;
   wire rd_w = bus_req_w & ~i_wb_we;
   wire [5:0] word_w = i_wb_adr[7:2];
   wire ctrl_wr_w = wr_w & (word_w == `RX_WORD_CTRL) & i_wb_sel[0];
   wire stat_wr_w = wr_w & (word_w == `RX_WORD_STAT) & i_wb_sel[0];
   wire div_wr_lo_w = wr_w & (word_w == `RX_WORD_DIV) & i_wb_sel[0];
   wire div_wr_hi_w = wr_w & (word_w == `RX_WORD_DIV) & i_wb_sel[1];
   wire data_rd_w = rd_w & (word_w == `RX_WORD_DATA);
   wire status_s stat_clr_w = stat_wr_w ? status_s'(i_wb_dat[4:0]) : status_s'(5'h00);
   wire [31:0] rd_mux_w =
      (word_w == `RX_WORD_CTRL) ? {27'h0, ctrl_r} :
      (word_w == `RX_WORD_STAT) ? {27'h0, status_r} :
      (word_w == `RX_WORD_DATA) ? {23'h0, rx_buf_r} :
      (word_w == `RX_WORD_DIV) ? {16'h0, div_r} : 32'h0;

   // Single wait state; unmapped words answer with zero
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0;
      end else begin
         o_wb_ack <= bus_req_w;
         o_wb_dat <= rd_w ? rd_mux_w : 32'h0;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         div_r <= `RX_DIV_RST;
      end else begin
         if (div_wr_lo_w) div_r[7:0] <= i_wb_dat[7:0];
         if (div_wr_hi_w) div_r[15:8] <= i_wb_dat[15:8];
      end
   end

   // ------------------------------------------------------------
   // Oversample tick
   // ------------------------------------------------------------
   rt_tick_gen u_tick (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_enable(ctrl_r.enable),
      .i_divisor(div_r),
      .o_tick(tick_w)
   );

   // ------------------------------------------------------------
   // Sampling decode
   // ------------------------------------------------------------
   wire run_w = tick_w & ctrl_r.enable;
   wire [2:0] ver_pat_w = {ver_r[1:0], i_rxd};
   wire [2:0] win_pat_w = {win_r[1:0], i_rxd};
   wire maj_w = majority3(win_pat_w);
   wire verify_ok_w = ~majority3(ver_pat_w);
   wire start_w = (hist_r == 3'h7) & ~i_rxd;
   wire edge_w = hist_r[0] & ~i_rxd;
   wire in_char_w = (state_r == ST_DATA) | (state_r == ST_STOP);
   wire resync_late_w = (state_r == ST_DATA) & last_vote_r & edge_w & (tick_cnt_r >= `RT_LATE_EDGE);
   wire resync_early_w = in_char_w & last_vote_r & edge_w & (tick_cnt_r <= `RT_EARLY_EDGE);
   wire last_bit_w = bit_idx_r == (ctrl_r.char9 ? `LAST_BIT_9 : `LAST_BIT_8);
   wire [4:0] tick_adv_w = (tick_cnt_r == `RT_LAST) ? `RT_FIRST : tick_cnt_r + 5'h01;
   wire in_win_w = (tick_cnt_r == `RT_WIN_A) | (tick_cnt_r == `RT_WIN_B);
   wire done_w = run_w & (state_r == ST_STOP) & (tick_cnt_r == `RT_WIN_C);

   // ------------------------------------------------------------
   // Receive sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      tick_nxt = tick_cnt_r;
      hist_nxt = hist_r;
      ver_nxt = ver_r;
      win_nxt = win_r;
      idx_nxt = bit_idx_r;
      shift_nxt = shift_r;
      vote_nxt = last_vote_r;
      noise_nxt = chr_noise_r;
      if (!ctrl_r.enable) begin
         state_nxt = ST_HUNT;
         hist_nxt = 3'h0;
      end else if (tick_w) begin
         hist_nxt = {hist_r[1:0], i_rxd};
         tick_nxt = tick_adv_w;
         if (in_win_w) win_nxt = win_pat_w;
         case (state_r)
            ST_HUNT: begin
               if (start_w) begin
                  state_nxt = ST_START;
                  tick_nxt = `RT_AFTER_EDGE;
                  noise_nxt = 1'b0;
                  ver_nxt = 3'h0;
               end
            end
            ST_START: begin
               if ((tick_cnt_r == `RT_VER_A) || (tick_cnt_r == `RT_VER_B)) ver_nxt = ver_pat_w;
               if (tick_cnt_r == `RT_VER_C) begin
                  if (!verify_ok_w) begin
                     // Fresh search needs three new highs
                     state_nxt = ST_HUNT;
                     hist_nxt = 3'h0;
                     tick_nxt = `RT_FIRST;
                  end else if (ver_pat_w != 3'h0) begin
                     noise_nxt = 1'b1;
                  end
               end
               // Late highs never undo an accepted start
               if ((tick_cnt_r == `RT_WIN_C) && (win_pat_w != 3'h0)) noise_nxt = 1'b1;
               if (tick_cnt_r == `RT_LAST) begin
                  state_nxt = ST_DATA;
                  idx_nxt = 4'h0;
                  vote_nxt = 1'b0;
               end
            end
            ST_DATA: begin
               if (tick_cnt_r == `RT_WIN_C) begin
                  shift_nxt = {maj_w, shift_r[8:1]};
                  vote_nxt = maj_w;
                  if (disagree3(win_pat_w)) noise_nxt = 1'b1;
               end
               if (resync_early_w) tick_nxt = `RT_AFTER_EDGE;
               if (resync_late_w || (tick_cnt_r == `RT_LAST)) begin
                  if (resync_late_w) tick_nxt = `RT_AFTER_EDGE;
                  if (last_bit_w) state_nxt = ST_STOP;
                  else idx_nxt = bit_idx_r + 4'h1;
               end
            end
            ST_STOP: begin
               if (resync_early_w) tick_nxt = `RT_AFTER_EDGE;
               if (tick_cnt_r == `RT_WIN_C) begin
                  // Stop samples seed the next start search
                  state_nxt = ST_HUNT;
                  hist_nxt = win_pat_w;
                  tick_nxt = `RT_FIRST;
               end
            end
            default: state_nxt = ST_HUNT;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_r <= ST_HUNT;
         tick_cnt_r <= `RT_FIRST;
         hist_r <= 3'h0;
         ver_r <= 3'h0;
         win_r <= 3'h0;
         bit_idx_r <= 4'h0;
         shift_r <= 9'h000;
         last_vote_r <= 1'b0;
         chr_noise_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tick_cnt_r <= tick_nxt;
         hist_r <= hist_nxt;
         ver_r <= ver_nxt;
         win_r <= win_nxt;
         bit_idx_r <= idx_nxt;
         shift_r <= shift_nxt;
         last_vote_r <= vote_nxt;
         chr_noise_r <= noise_nxt;
      end
   end

   // ------------------------------------------------------------
   // Character completion and idle detection
   // ------------------------------------------------------------
   wire addr_wake_w = ctrl_r.standby & ctrl_r.wake_addr & shift_r[8];
   wire rbf_set_w = done_w & (~ctrl_r.standby | addr_wake_w);
   // Break gives a low stop vote, so it lands here too
   wire fe_set_w = rbf_set_w & ~maj_w;
   wire nf_set_w = rbf_set_w & (chr_noise_r | disagree3(win_pat_w));
   wire [8:0] char_w = ctrl_r.char9 ? shift_r : {1'b0, shift_r[8:1]};
   wire [7:0] idle_thr_w = ctrl_r.char9 ? `IDLE_TICKS_9 : `IDLE_TICKS_8;
   // Idle count may be held off until the stop bit is voted at tick 10
   wire idle_count_ok_w = i_rxd & ~(ctrl_r.idle_count_start_select & (state_r != ST_HUNT));
   wire idle_hit_w = run_w & idle_count_ok_w & (idle_cnt_r == idle_thr_w - 8'h01);
   wire idle_full_w = ctrl_r.enable & (idle_cnt_r == idle_thr_w);
   wire idle_wake_w = ctrl_r.standby & ~ctrl_r.wake_addr & idle_full_w;
   wire idle_set_w = idle_hit_w & idle_armed_r & ~ctrl_r.standby;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         idle_cnt_r <= 8'h00;
         idle_armed_r <= 1'b0;
      end else if (run_w) begin
         if (!idle_count_ok_w) idle_cnt_r <= 8'h00;
         else if (idle_cnt_r != idle_thr_w) idle_cnt_r <= idle_cnt_r + 8'h01;
         if (start_w && (state_r == ST_HUNT)) idle_armed_r <= 1'b1;
         else if (idle_hit_w) idle_armed_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Control and status
   // ------------------------------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (ctrl_wr_w) ctrl_nxt = ctrl_s'(i_wb_dat[4:0]);
      else if ((done_w && addr_wake_w) || idle_wake_w) ctrl_nxt.standby = 1'b0;
      // A hardware set outlives a clear in the same cycle
      status_nxt.rbf = rbf_set_w | (status_r.rbf & ~data_rd_w);
      status_nxt.idle = idle_set_w | (status_r.idle & ~stat_clr_w.idle);
      status_nxt.nf = nf_set_w | (status_r.nf & ~stat_clr_w.nf);
      status_nxt.fe = fe_set_w | (status_r.fe & ~stat_clr_w.fe);
      status_nxt.active = state_nxt != ST_HUNT;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ctrl_r <= ctrl_s'(`RX_CTRL_RST);
         status_r <= status_s'(`RX_STAT_RST);
         rx_buf_r <= 9'h000;
         o_rx_request <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         status_r <= status_nxt;
         if (rbf_set_w) rx_buf_r <= char_w;
         o_rx_request <= (status_r.rbf | status_r.idle) & ~ctrl_r.standby;
      end
   end

   assign o_standby = ctrl_r.standby;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   property p_tick_range;
      (tick_cnt_r >= `RT_FIRST) && (tick_cnt_r <= `RT_LAST);
   endproperty
   a_tick_range: assert property (p_tick_range) else $error("tick counter out of range");

   property p_start_found;
      (run_w && state_r == ST_HUNT && start_w) |=> (state_r == ST_START) && (tick_cnt_r == `RT_AFTER_EDGE);
   endproperty
   a_start_found: assert property (p_start_found) else $error("start edge not taken");

   property p_start_reject;
      (run_w && state_r == ST_START && tick_cnt_r == `RT_VER_C && majority3(ver_pat_w)) |=>
         (state_r == ST_HUNT) && (hist_r == 3'h0);
   endproperty
   a_start_reject: assert property (p_start_reject) else $error("bad start not rejected");

   property p_start_late_noise;
      (run_w && state_r == ST_START && tick_cnt_r == `RT_WIN_C && win_pat_w != 3'h0) |=>
         chr_noise_r && (state_r == ST_START);
   endproperty
   a_start_late_noise: assert property (p_start_late_noise) else $error("start late high mishandled");

   property p_data_vote;
      (run_w && state_r == ST_DATA && tick_cnt_r == `RT_WIN_C) |=> shift_r[8] == $past(maj_w);
   endproperty
   a_data_vote: assert property (p_data_vote) else $error("data bit not majority");

   property p_fe_with_rbf;
      $rose(status_r.fe) |-> status_r.rbf && $past(done_w);
   endproperty
   a_fe_with_rbf: assert property (p_fe_with_rbf) else $error("stop error apart from buffer full");

   property p_stop_low;
      (done_w && !maj_w && !ctrl_r.standby) |=> status_r.fe && status_r.rbf;
   endproperty
   a_stop_low: assert property (p_stop_low) else $error("low stop without error");

   property p_standby_quiet;
      ctrl_r.standby |=> !o_rx_request;
   endproperty
   a_standby_quiet: assert property (p_standby_quiet) else $error("request in standby");

   property p_addr_wake;
      (done_w && addr_wake_w && !ctrl_wr_w) |=> !ctrl_r.standby && status_r.rbf;
   endproperty
   a_addr_wake: assert property (p_addr_wake) else $error("address mark did not wake");

   property p_idle_wake;
      (idle_wake_w && !ctrl_wr_w) |=> !ctrl_r.standby && !$rose(status_r.idle) && !$rose(status_r.rbf);
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");

   property p_resync;
      (run_w && resync_late_w) |=> tick_cnt_r == `RT_AFTER_EDGE;
   endproperty
   a_resync: assert property (p_resync) else $error("no realign on edge");

   c_char_done: cover property (done_w && maj_w);
   c_break: cover property (done_w && shift_r == 9'h000 && !maj_w);
   c_addr_wake: cover property (done_w && addr_wake_w);
   c_idle_wake: cover property (idle_wake_w);

endmodule
`default_nettype wire

// ---- verif/serial_tx_model.sv ----
/*
   Transmitter model on the receiver's serial input: frames, glitches, pulses.
   Assumes the bench calls its tasks from one process and idles the line high.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
   // Clock
   input wire logic i_clock,
   // Serial line
   output logic o_line
);
   // ------------------------------
   // Line driving
   // ------------------------------
   initial o_line = 1'b1;

   // Low for n clocks, then idle again
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge i_clock);
         o_line <= 1'b0;
      end
      @(posedge i_clock);
      o_line <= 1'b1;
   endtask

   // LSB first; glitch flips one clock (-1 none); blen clocks per bit
   task automatic send(input logic [8:0] d, input logic nine, input logic stop,
                       input int glitch, input int blen);
      logic [10:0] fr;
      int nb;
      fr = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
      nb = nine ? 11 : 10;
      for (int k = 0; k < nb * blen; k++) begin
         @(posedge i_clock);
         o_line <= fr[k / blen] ^ (k == glitch);
      end
      // A break leaves the line low, so always return to idle
      @(posedge i_clock);
      o_line <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- verif/tb_uart_rx_sampling_wakeup.sv ----
/*
   Self-checking bench: Wishbone register access plus characters from the model.
   Assumes DIV is written to zero, so one bit lasts sixteen clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_uart_rx_sampling_wakeup;
   // ------------------------------
   // Signals and instances
   // ------------------------------
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_wdat = 32'h0;
   logic [3:0] wb_sel = 4'h0;
   wire [31:0] wb_rdat;
   wire wb_ack;
   wire rxd;
   wire rx_request;
   wire standby;
   int num_errors = 0;
   int n_compared = 0;

   always #5 clock = ~clock;

   uart_rx_sampling_wakeup DUT (
      .i_clock(clock), .i_rst(rst),
      .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
      .i_wb_dat(wb_wdat), .i_wb_sel(wb_sel), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
      .i_rxd(rxd), .o_rx_request(rx_request), .o_standby(standby)
   );

   serial_tx_model tx (.i_clock(clock), .o_line(rxd));

   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic end_sim();
      if (num_errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t read got %h exp %h", $time, got, exp);
      end
   endtask

   // Pins are looked at mid-cycle, once the edge's updates have landed
   task automatic chk_pins(input logic exp_req, input logic exp_stby);
      @(negedge clock);
      n_compared++;
      if ({rx_request, standby} !== {exp_req, exp_stby}) begin
         num_errors++;
         $display("MISMATCH %0t pins got %b%b exp %b%b", $time, rx_request, standby, exp_req, exp_stby);
      end
   endtask

   // Classic cycle: held until ack is sampled, then released for a cycle
   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clock);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= d;
      wb_sel <= 4'hf;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (wb_ack !== 1'b1) begin
         num_errors++;
         $display("MISMATCH %0t bus timeout", $time);
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb_cycle(1'b0, a, 32'h0, q);
      chk_word(q, exp);
   endtask

   // One awake character: status, request pin, data, then flags cleared
   task automatic run_char(input logic [8:0] d, input logic nine, input logic stop,
                           input int glitch, input int blen, input logic [31:0] stat);
      wr(8'h00, {30'h0, nine, 1'b1});
      // A freshly enabled receiver needs three idle highs before a start
      repeat (4) @(posedge clock);
      tx.send(d, nine, stop, glitch, blen);
      rd_chk(8'h04, stat);
      chk_pins(1'b1, 1'b0);
      rd_chk(8'h08, {23'h0, d});
      wr(8'h04, 32'he);
   endtask

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h08, 32'h0);
      rd_chk(8'h0c, 32'h35);
      rd_chk(8'h10, 32'h0);
      chk_pins(1'b0, 1'b0);
      wr(8'h0c, 32'h0);
      run_char(9'h0a5, 1'b0, 1'b1, -1, 16, 32'h1);
      run_char(9'h03c, 1'b0, 1'b1, 4, 16, 32'h5);
      run_char(9'h03c, 1'b0, 1'b1, 8, 16, 32'h5);
      run_char(9'h03c, 1'b0, 1'b1, 24, 16, 32'h5);
      run_char(9'h03c, 1'b0, 1'b0, -1, 16, 32'h9);
      run_char(9'h03c, 1'b0, 1'b1, 152, 16, 32'h5);
      run_char(9'h000, 1'b0, 1'b0, -1, 16, 32'h9);
      run_char(9'h055, 1'b0, 1'b1, -1, 15, 32'h1);
      run_char(9'h1a5, 1'b1, 1'b1, -1, 16, 32'h1);
      // Rejected start, then a proper character must still be found
      tx.pulse(4);
      repeat (20) @(posedge clock);
      rd_chk(8'h04, 32'h0);
      run_char(9'h05a, 1'b0, 1'b1, -1, 16, 32'h1);
      // Idle counted from data highs versus from the stop bit
      wr(8'h00, 32'h1);
      tx.send(9'h0f0, 1'b0, 1'b1, -1, 16);
      repeat (120) @(posedge clock);
      rd_chk(8'h04, 32'h3);
      rd_chk(8'h08, 32'hf0);
      wr(8'h04, 32'he);
      wr(8'h00, 32'h9);
      tx.send(9'h0f0, 1'b0, 1'b1, -1, 16);
      repeat (120) @(posedge clock);
      rd_chk(8'h04, 32'h1);
      repeat (80) @(posedge clock);
      rd_chk(8'h04, 32'h3);
      chk_pins(1'b1, 1'b0);
      rd_chk(8'h08, 32'hf0);
      wr(8'h04, 32'he);
      // Address-mark wake
      wr(8'h00, 32'h15);
      tx.send(9'h012, 1'b0, 1'b1, -1, 16);
      chk_pins(1'b0, 1'b1);
      rd_chk(8'h04, 32'h0);
      tx.send(9'h092, 1'b0, 1'b1, -1, 16);
      chk_pins(1'b1, 1'b0);
      rd_chk(8'h04, 32'h1);
      rd_chk(8'h08, 32'h92);
      wr(8'h00, 32'h15);
      chk_pins(1'b0, 1'b1);
      // Idle-line wake, then wake on standby set over an idle line
      wr(8'h00, 32'h1);
      tx.send(9'h033, 1'b0, 1'b1, -1, 16);
      rd_chk(8'h08, 32'h33);
      wr(8'h00, 32'h11);
      tx.send(9'h044, 1'b0, 1'b1, -1, 16);
      chk_pins(1'b0, 1'b1);
      repeat (200) @(posedge clock);
      chk_pins(1'b0, 1'b0);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h08, 32'h33);
      wr(8'h00, 32'h11);
      repeat (4) @(posedge clock);
      chk_pins(1'b0, 1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
